// ---- logic/timer_ocmp_pkg.sv ----
// Register map, field positions and reset values of the compare timer.
// Assumes a 32-bit AHB-Lite bus, one byte-wide register per word.
package timer_ocmp_pkg;
   // Byte addresses of the registers
   localparam logic [7:0] OFS_CTRL_ONE = 8'h00;
   localparam logic [7:0] OFS_CTRL_TWO = 8'h04;
   localparam logic [7:0] OFS_STATUS   = 8'h08;
   localparam logic [7:0] OFS_CMP1_HI  = 8'h0C;
   localparam logic [7:0] OFS_CMP1_LO  = 8'h10;
   localparam logic [7:0] OFS_CMP2_HI  = 8'h14;
   localparam logic [7:0] OFS_CMP2_LO  = 8'h18;
   localparam logic [7:0] OFS_CNT_HI   = 8'h1C;
   localparam logic [7:0] OFS_CNT_LO   = 8'h20;
   localparam logic [7:0] OFS_ACNT_HI  = 8'h24;
   localparam logic [7:0] OFS_ACNT_LO  = 8'h28;
   localparam logic [7:0] OFS_CAP1_HI  = 8'h2C;
   localparam logic [7:0] OFS_CAP1_LO  = 8'h30;
   // Control register one fields
   localparam int CR1_OLVL1 = 0;
   localparam int CR1_OLVL2 = 1;
   localparam int CR1_FOLV1 = 2;
   localparam int CR1_FOLV2 = 3;
   localparam int CR1_COMPARE_IRQ_ENABLE  = 4;
   localparam int CR1_CAPTURE_IRQ_ENABLE  = 5;
   localparam int CR1_CAPTURE_EDGE_SELECT_ONE = 6;
   // Control register two fields
   localparam int CR2_OC1E  = 0;
   localparam int CR2_OC2E  = 1;
   localparam int CR2_OPM   = 2;
   localparam int CR2_PWM   = 3;
   localparam int CR2_CC_LO = 4;
   localparam int CR2_EXEDG = 6;
   // Status register fields
   localparam int ST_OCF1 = 0;
   localparam int ST_OCF2 = 1;
   localparam int ST_CAPTURE_FLAG_ONE = 2;
   // Reset and reload values
   localparam logic [15:0] CMP_RESET   = 16'h8000;
   localparam logic [15:0] CNT_RELOAD  = 16'hFFFC;
   localparam logic [15:0] CAP_TRIGGER = 16'hFFFD;
   // Timer clock selections and prescaler masks
   localparam logic [1:0] CLK_DIV2 = 2'h0;
   localparam logic [1:0] CLK_DIV4 = 2'h1;
   localparam logic [1:0] CLK_DIV8 = 2'h2;
   localparam logic [1:0] CLK_EXT  = 2'h3;
   localparam logic [2:0] PRE_MASK_DIV2 = 3'h1;
   localparam logic [2:0] PRE_MASK_DIV4 = 3'h3;
   localparam logic [2:0] PRE_MASK_DIV8 = 3'h7;
endpackage : timer_ocmp_pkg

// ---- logic/timer_output_compare_pulse.sv ----
// Output-compare timer: counter, two compare channels, one-pulse and PWM.
// Assumes an AHB-Lite master, pins synchronous to clk_sys_i.

// Function
// - Compare equality sets match flag, drives enabled pin level, may interrupt.
// - Two 16-bit compare values, high and low byte, checked every timer tick.
// - Compare values software read/write, untouched by hardware, reset to 8000h.
// - Pin latch low in reset; after a match pin takes the level bit.
// - Compare interrupt needs enable set and global mask clear.
// - Flag clears after status read with flag set, then low byte access.
// - High byte write stops comparing until the low byte is written.
// - Pin enable clear: pin stays port, no level, interrupt still possible.
// - Divide-by-two matches at equality; other clocks at value plus one.
// - Force bit copies level to enabled pin, no flag; ignored in pulse modes.
// - Single-pulse select bit picks one-pulse mode using capture one, compare one.
// - One-pulse trigger: counter FFFCh, second level out, flag, capture FFFDh.
// - One-pulse capture flag may interrupt; cleared by status read, low access.
// - One-pulse: first compare match drives first level, ending the pulse.
// - One-pulse: no first compare flag; second compare flags only, no waveform.
// - PWM wins over one-pulse; equal levels give a constant pin.
// - One-pulse: first capture pin captures nothing itself.
// - PWM uses compare one fully plus compare two value.
// - PWM compare values double-buffered, applied at second compare match.
// - Reduced instance: compare two write-only, second flag held zero.
// - Counter low byte write reloads counter to FFFCh, its reset value.
// - Clock select both ones picks external clock; else CPU by 2, 4, 8.
// - PWM: second compare match reloads counter to FFFCh.
// - PWM: pin takes first level on match one, second on match two.
module timer_output_compare_pulse #(
   parameter bit REDUCED_P = 1'b0
) (
   // Clock and reset
   input  wire logic        clk_sys_i,
   input  wire logic        rst_b_i,
   // AHB-Lite slave
   input  wire logic        hsel_i,
   input  wire logic [31:0] haddr_i,
   input  wire logic [1:0]  htrans_i,
   input  wire logic        hwrite_i,
   input  wire logic [2:0]  hsize_i,
   input  wire logic [31:0] hwdata_i,
   input  wire logic        hready_i,
   output logic      [31:0] hrdata_o,
   output logic             hreadyout_o,
   output logic             hresp_o,
   // Timer pins and core mask
   input  wire logic        capture_input_pin_one_i,
   input  wire logic        ext_clk_i,
   input  wire logic        irq_mask_i,
   output logic      [1:0]  compare_output_pin_o,
   output logic      [1:0]  compare_pin_oe_o,
   output logic             timer_irq_o
);

   typedef struct packed {
      logic [1:0][15:0] cmp;
      logic [1:0][15:0] active;
      logic [1:0]       inhibit;
      logic [1:0]       ocf;
      logic [1:0]       arm_ocf;
      logic [1:0]       pin;
      logic [1:0]       pin_oe;
      logic             capture_flag_one;
      logic             arm_capture_flag_one;
      logic             cap_inhibit;
      logic [15:0]      cap1;
      logic [15:0]      cnt;
      logic [7:0]       ctrl1;
      logic [7:0]       ctrl2;
      logic [7:0]       cnt_lo_buf;
      logic             cnt_buf_v;
      logic [2:0]       pre;
      logic             tick_d;
      logic             ext_d;
      logic             icap_d;
      logic             ph_valid;
      logic             ph_write;
      logic [7:0]       ph_addr;
      logic [31:0]      hrdata;
      logic             rdy;
      logic             irq;
   } tmr_state_t;

   localparam tmr_state_t RST_VAL = '{
      cmp:     {timer_ocmp_pkg::CMP_RESET, timer_ocmp_pkg::CMP_RESET},
      active:  {timer_ocmp_pkg::CMP_RESET, timer_ocmp_pkg::CMP_RESET},
      cnt:     timer_ocmp_pkg::CNT_RELOAD,
      rdy:     1'b1,
      default: '0
   };

   tmr_state_t s_r;
   tmr_state_t s_nxt;

   logic       pwm_m;
   logic       opm_m;
   logic       div2_m;
   logic [1:0] cc_sel;
   logic [1:0] match_w;
   logic       trig_w;

   // Mode decode; PWM overrides one-pulse
   assign cc_sel = s_r.ctrl2[timer_ocmp_pkg::CR2_CC_LO +: 2];
   assign pwm_m  = s_r.ctrl2[timer_ocmp_pkg::CR2_PWM];
   assign opm_m  = s_r.ctrl2[timer_ocmp_pkg::CR2_OPM] & ~pwm_m;
   assign div2_m = (cc_sel == timer_ocmp_pkg::CLK_DIV2);

   // Trigger edge on the first capture pin
   assign trig_w = s_r.ctrl1[timer_ocmp_pkg::CR1_CAPTURE_EDGE_SELECT_ONE]
                   ? (capture_input_pin_one_i & ~s_r.icap_d)
                   : (~capture_input_pin_one_i & s_r.icap_d);

   // Per-channel equality, one check after each counter step
   for (genvar ch = 0; ch < 2; ch++) begin : g_match
      logic [15:0] cmp_sel;
      logic [15:0] tgt;
      assign cmp_sel = pwm_m ? s_r.active[ch] : s_r.cmp[ch];
      assign tgt = div2_m ? cmp_sel : 16'(cmp_sel + 16'h0001);
      assign match_w[ch] = s_r.tick_d & ~s_r.inhibit[ch]
                           & (s_r.cnt == tgt);
   end

   // Next-state logic of the whole block
   always_comb begin
      logic       wr;
      logic       rd;
      logic [7:0] wd;
      logic [7:0] ra;
      logic [7:0] rv;
      logic       tick;
      logic       ext_edge;
      logic [2:0] mask;
      wr = s_r.ph_valid & s_r.ph_write;
      rd = hsel_i & htrans_i[1] & hready_i & ~hwrite_i;
      wd = hwdata_i[7:0];
      ra = haddr_i[7:0];
      rv = 8'h00;
      tick = 1'b0;
      ext_edge = 1'b0;
      mask = timer_ocmp_pkg::PRE_MASK_DIV2;
      s_nxt = s_r;
      s_nxt.tick_d = 1'b0;
      s_nxt.ext_d = ext_clk_i;
      s_nxt.icap_d = capture_input_pin_one_i;
      s_nxt.rdy = 1'b1;

      // Data phase of a write
      if (wr) begin
         case (s_r.ph_addr)
            timer_ocmp_pkg::OFS_CTRL_ONE: begin
               s_nxt.ctrl1 = {1'b0, wd[6:0]};
               for (int ch = 0; ch < 2; ch++) begin
                  if (wd[timer_ocmp_pkg::CR1_FOLV1 + ch] && !opm_m
                      && !pwm_m && s_r.pin_oe[ch]) begin
                     s_nxt.pin[ch] = wd[timer_ocmp_pkg::CR1_OLVL1 + ch];
                  end
               end
            end
            timer_ocmp_pkg::OFS_CTRL_TWO: s_nxt.ctrl2 = {1'b0, wd[6:0]};
            timer_ocmp_pkg::OFS_CMP1_HI: begin
               s_nxt.cmp[0][15:8] = wd;
               s_nxt.inhibit[0] = 1'b1;
            end
            timer_ocmp_pkg::OFS_CMP1_LO: begin
               s_nxt.cmp[0][7:0] = wd;
               s_nxt.inhibit[0] = 1'b0;
               if (s_r.arm_ocf[0]) begin
                  s_nxt.ocf[0] = 1'b0;
                  s_nxt.arm_ocf[0] = 1'b0;
               end
            end
            timer_ocmp_pkg::OFS_CMP2_HI: begin
               s_nxt.cmp[1][15:8] = wd;
               s_nxt.inhibit[1] = 1'b1;
            end
            timer_ocmp_pkg::OFS_CMP2_LO: begin
               s_nxt.cmp[1][7:0] = wd;
               s_nxt.inhibit[1] = 1'b0;
               if (s_r.arm_ocf[1]) begin
                  s_nxt.ocf[1] = 1'b0;
                  s_nxt.arm_ocf[1] = 1'b0;
               end
            end
            timer_ocmp_pkg::OFS_CAP1_LO: begin
               if (s_r.arm_capture_flag_one) begin
                  s_nxt.capture_flag_one = 1'b0;
                  s_nxt.arm_capture_flag_one = 1'b0;
               end
            end
            default: ;
         endcase
      end

      // Address-phase read side effects
      if (rd) begin
         case (ra)
            timer_ocmp_pkg::OFS_STATUS: begin
               s_nxt.arm_ocf = s_nxt.arm_ocf | s_r.ocf;
               s_nxt.arm_capture_flag_one = s_nxt.arm_capture_flag_one | s_r.capture_flag_one;
            end
            timer_ocmp_pkg::OFS_CMP1_LO: begin
               if (s_r.arm_ocf[0]) begin
                  s_nxt.ocf[0] = 1'b0;
                  s_nxt.arm_ocf[0] = 1'b0;
               end
            end
            timer_ocmp_pkg::OFS_CMP2_LO: begin
               if (s_r.arm_ocf[1]) begin
                  s_nxt.ocf[1] = 1'b0;
                  s_nxt.arm_ocf[1] = 1'b0;
               end
            end
            timer_ocmp_pkg::OFS_CAP1_HI: s_nxt.cap_inhibit = 1'b1;
            timer_ocmp_pkg::OFS_CAP1_LO: begin
               s_nxt.cap_inhibit = 1'b0;
               if (s_r.arm_capture_flag_one) begin
                  s_nxt.capture_flag_one = 1'b0;
                  s_nxt.arm_capture_flag_one = 1'b0;
               end
            end
            timer_ocmp_pkg::OFS_CNT_HI, timer_ocmp_pkg::OFS_ACNT_HI: begin
               if (!s_r.cnt_buf_v) begin
                  s_nxt.cnt_lo_buf = s_r.cnt[7:0];
                  s_nxt.cnt_buf_v = 1'b1;
               end
            end
            timer_ocmp_pkg::OFS_CNT_LO, timer_ocmp_pkg::OFS_ACNT_LO:
               s_nxt.cnt_buf_v = 1'b0;
            default: ;
         endcase
      end

      // Timer clock: CPU divided by 2, 4, 8 or external edge
      case (cc_sel)
         timer_ocmp_pkg::CLK_DIV4: mask = timer_ocmp_pkg::PRE_MASK_DIV4;
         timer_ocmp_pkg::CLK_DIV8: mask = timer_ocmp_pkg::PRE_MASK_DIV8;
         default: mask = timer_ocmp_pkg::PRE_MASK_DIV2;
      endcase
      ext_edge = s_r.ctrl2[timer_ocmp_pkg::CR2_EXEDG]
                 ? (ext_clk_i & ~s_r.ext_d) : (~ext_clk_i & s_r.ext_d);
      if (cc_sel == timer_ocmp_pkg::CLK_EXT) begin
         tick = ext_edge;
      end else begin
         tick = ((s_r.pre & mask) == mask);
         s_nxt.pre = 3'(s_r.pre + 3'h1);
      end
      if (tick) begin
         s_nxt.cnt = 16'(s_r.cnt + 16'h0001);
         s_nxt.tick_d = 1'b1;
      end

      // Compare events per mode; hardware sets win over clears
      if (pwm_m) begin
         if (match_w[0] && s_r.pin_oe[0]) begin
            s_nxt.pin[0] = s_r.ctrl1[timer_ocmp_pkg::CR1_OLVL1];
         end
         if (match_w[1]) begin
            if (s_r.pin_oe[0]) begin
               s_nxt.pin[0] = s_r.ctrl1[timer_ocmp_pkg::CR1_OLVL2];
            end
            s_nxt.cnt = timer_ocmp_pkg::CNT_RELOAD;
            s_nxt.pre = 3'h0;
            s_nxt.capture_flag_one = 1'b1;
            s_nxt.active = s_nxt.cmp;
         end
      end else begin
         for (int ch = 0; ch < 2; ch++) begin
            if (match_w[ch]) begin
               if (opm_m && ch == 0) begin
                  if (s_r.pin_oe[0]) begin
                     s_nxt.pin[0] =
                        s_r.ctrl1[timer_ocmp_pkg::CR1_OLVL1];
                  end
               end else begin
                  s_nxt.ocf[ch] = 1'b1;
                  if (s_r.pin_oe[ch] && !opm_m) begin
                     s_nxt.pin[ch] =
                        s_r.ctrl1[timer_ocmp_pkg::CR1_OLVL1 + ch];
                  end
               end
            end
         end
         // Trigger edge or plain capture on the first capture pin
         if (trig_w && opm_m) begin
            s_nxt.cnt = timer_ocmp_pkg::CNT_RELOAD;
            s_nxt.pre = 3'h0;
            s_nxt.capture_flag_one = 1'b1;
            s_nxt.cap1 = timer_ocmp_pkg::CAP_TRIGGER;
            if (s_r.pin_oe[0]) begin
               s_nxt.pin[0] = s_r.ctrl1[timer_ocmp_pkg::CR1_OLVL2];
            end
         end else if (trig_w && !s_r.cap_inhibit) begin
            s_nxt.cap1 = s_r.cnt;
            s_nxt.capture_flag_one = 1'b1;
         end
      end
      if (REDUCED_P) begin
         s_nxt.ocf[1] = 1'b0;
      end

      // Software counter reload has the last word
      if (wr && (s_r.ph_addr == timer_ocmp_pkg::OFS_CNT_LO
                 || s_r.ph_addr == timer_ocmp_pkg::OFS_ACNT_LO)) begin
         s_nxt.cnt = timer_ocmp_pkg::CNT_RELOAD;
         s_nxt.pre = 3'h0;
         s_nxt.tick_d = 1'b0;
      end

      // Pin enables follow control register two
      s_nxt.pin_oe = {s_nxt.ctrl2[timer_ocmp_pkg::CR2_OC2E],
                      s_nxt.ctrl2[timer_ocmp_pkg::CR2_OC1E]};

      // Single timer interrupt, gated by the core mask
      s_nxt.irq = ~irq_mask_i
                  & ((|s_nxt.ocf & s_nxt.ctrl1[timer_ocmp_pkg::CR1_COMPARE_IRQ_ENABLE])
                   | (s_nxt.capture_flag_one & s_nxt.ctrl1[timer_ocmp_pkg::CR1_CAPTURE_IRQ_ENABLE]));

      // Read mux sees control and compare writes of the current data phase; status and counter show the registered state
      case (ra)
         timer_ocmp_pkg::OFS_CTRL_ONE: rv = s_nxt.ctrl1;
         timer_ocmp_pkg::OFS_CTRL_TWO: rv = s_nxt.ctrl2;
         timer_ocmp_pkg::OFS_STATUS:
            rv = {5'h00, s_r.capture_flag_one, s_r.ocf[1], s_r.ocf[0]};
         timer_ocmp_pkg::OFS_CMP1_HI: rv = s_nxt.cmp[0][15:8];
         timer_ocmp_pkg::OFS_CMP1_LO: rv = s_nxt.cmp[0][7:0];
         timer_ocmp_pkg::OFS_CMP2_HI:
            rv = REDUCED_P ? 8'h00 : s_nxt.cmp[1][15:8];
         timer_ocmp_pkg::OFS_CMP2_LO:
            rv = REDUCED_P ? 8'h00 : s_nxt.cmp[1][7:0];
         timer_ocmp_pkg::OFS_CNT_HI, timer_ocmp_pkg::OFS_ACNT_HI:
            rv = s_r.cnt[15:8];
         timer_ocmp_pkg::OFS_CNT_LO, timer_ocmp_pkg::OFS_ACNT_LO:
            rv = s_r.cnt_buf_v ? s_r.cnt_lo_buf : s_r.cnt[7:0];
         timer_ocmp_pkg::OFS_CAP1_HI: rv = s_r.cap1[15:8];
         timer_ocmp_pkg::OFS_CAP1_LO: rv = s_r.cap1[7:0];
         default: rv = 8'h00;
      endcase

      // Address phase capture
      s_nxt.ph_valid = hsel_i & htrans_i[1] & hready_i;
      s_nxt.ph_write = hwrite_i;
      s_nxt.ph_addr = ra;
      s_nxt.hrdata = rd ? {24'h00_0000, rv} : 32'h0000_0000;
   end

   // State register; reset clears flags and force bits, pins low
   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         s_r <= RST_VAL;
      end else begin
         s_r <= s_nxt;
      end
   end

   // Outputs straight from the state register; hresp_o tied low
   assign hrdata_o             = s_r.hrdata;
   assign hreadyout_o          = s_r.rdy;
   assign hresp_o              = 1'b0;
   assign compare_output_pin_o = s_r.pin;
   assign compare_pin_oe_o     = s_r.pin_oe;
   assign timer_irq_o          = s_r.irq;

   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!rst_b_i);

   sequence s_status_read;
      hsel_i && htrans_i[1] && hready_i && !hwrite_i
      && haddr_i[7:0] == timer_ocmp_pkg::OFS_STATUS;
   endsequence
   sequence s_low1_read;
      hsel_i && htrans_i[1] && hready_i && !hwrite_i
      && haddr_i[7:0] == timer_ocmp_pkg::OFS_CMP1_LO && !match_w[0];
   endsequence

   property p_flag_on_match;
      match_w[0] && !pwm_m && !opm_m |=> s_r.ocf[0];
   endproperty
   a_flag_on_match: assert property (p_flag_on_match)
      else $error("compare one match did not set its flag");

   property p_pin_level;
      match_w[1] && !pwm_m && !opm_m && s_r.pin_oe[1]
      |=> s_r.pin[1] == $past(s_r.ctrl1[timer_ocmp_pkg::CR1_OLVL2]);
   endproperty
   a_pin_level: assert property (p_pin_level)
      else $error("compare two pin did not take its level");

   property p_irq_gate;
      timer_irq_o |-> !$past(irq_mask_i) && ($past(|s_nxt.ocf)
                      || $past(s_nxt.capture_flag_one));
   endproperty
   a_irq_gate: assert property (p_irq_gate)
      else $error("interrupt raised without a flag or while masked");

   property p_flag_clear;
      s_r.ocf[0] ##0 s_status_read ##2 s_low1_read |=> !s_r.ocf[0];
   endproperty
   a_flag_clear: assert property (p_flag_clear)
      else $error("status read then low read did not clear flag one");

   property p_inhibit;
      s_r.inhibit[0] |=> !$rose(s_r.ocf[0]);
   endproperty
   a_inhibit: assert property (p_inhibit)
      else $error("compare one active while high byte write pending");

   property p_no_flag_opm;
      $rose(s_r.ocf[0]) |-> !$past(opm_m) && !$past(pwm_m);
   endproperty
   a_no_flag_opm: assert property (p_no_flag_opm)
      else $error("compare one flag set in a pulse mode");

   property p_trigger;
      trig_w && opm_m |=> s_r.cnt == timer_ocmp_pkg::CNT_RELOAD
         && s_r.cap1 == timer_ocmp_pkg::CAP_TRIGGER && s_r.capture_flag_one;
   endproperty
   a_trigger: assert property (p_trigger)
      else $error("one-pulse trigger did not reload counter and capture");

   property p_pwm_period;
      pwm_m && match_w[1] |=> s_r.cnt == timer_ocmp_pkg::CNT_RELOAD
         && s_r.active == $past(s_nxt.cmp) && s_r.ocf == $past(s_r.ocf);
   endproperty
   a_pwm_period: assert property (p_pwm_period)
      else $error("PWM period end did not reload and apply buffers");

   property p_reduced;
      REDUCED_P |-> s_r.ocf[1] == 1'b0;
   endproperty
   a_reduced: assert property (p_reduced)
      else $error("second flag set in reduced instance");
endmodule : timer_output_compare_pulse

// ---- testbench/ocmp_far_side.sv ----
// Far-side model: trigger source on the first capture pin, pin watcher.
// Assumes pins synchronous to the system clock; no external timer clock.
module ocmp_far_side (
   // Clock
   input  wire logic        clk_i,
   // Bench command and watched compare pins
   input  wire logic        fire_i,
   input  wire logic [1:0]  pin_i,
   // Driven towards the timer
   output logic             trig_o,
   output logic             ext_clk_o,
   // Cycles the first compare pin stood high since the last fire
   output logic      [15:0] high_cnt_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [2:0] hold_r;
   // Trigger held four clocks so the edge flop surely sees it
   always @(posedge clk_i) begin
      if (fire_i && hold_r == 3'h0) hold_r <= 3'h4;
      else if (hold_r != 3'h0) hold_r <= hold_r - 3'h1;
      if (fire_i) high_cnt_o <= 16'h0000;
      else if (pin_i[0]) high_cnt_o <= high_cnt_o + 16'h0001;
   end
   initial hold_r = 3'h0;
   initial high_cnt_o = 16'h0000;
   // Trigger idles low; external clock stands still, unused here
   assign trig_o    = (hold_r != 3'h0);
   assign ext_clk_o = 1'b0;
endmodule : ocmp_far_side

// ---- testbench/timer_output_compare_pulse_test.sv ----
// Self-checking bench: reset, force, compare, flag clear, one pulse.
// Assumes an AHB-Lite slave; timer clock by two unless a task picks another.
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin fails++; \
   $display("unexpected %s exp %h got %h", nm, e, g); end end
module timer_output_compare_pulse_test;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_sys_i, rst_b_i, hsel, hwrite, hready, hresp, trig, ext_clk;
   logic irq_mask, irq, fire;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0]  htrans, pins, oe;
   logic [2:0]  hsize;
   logic [15:0] high_cnt;
   logic [7:0]  q;
   int fails, n_tests;
   timer_output_compare_pulse u_timer_output_compare_pulse (
      .clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .hsel_i(hsel),
      .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
      .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hready),
      .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
      .capture_input_pin_one_i(trig), .ext_clk_i(ext_clk),
      .irq_mask_i(irq_mask), .compare_output_pin_o(pins),
      .compare_pin_oe_o(oe), .timer_irq_o(irq));
   ocmp_far_side u_ocmp_far_side (.clk_i(clk_sys_i), .fire_i(fire),
      .pin_i(pins), .trig_o(trig), .ext_clk_o(ext_clk),
      .high_cnt_o(high_cnt));
   // Verdict and end of run
   task automatic end_sim;
      $display("comparisons %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : end_sim
   // Bounded wait for hready sampled high at a rising edge
   task automatic wait_rdy;
      int n;
      n = 0;
      @(posedge clk_sys_i);
      while (hready !== 1'b1) begin
         @(posedge clk_sys_i);
         n++;
         if (n > 20) begin fails++; end_sim(); end
      end
   endtask : wait_rdy
   // One single word transfer: address phase, then data phase
   task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= {24'h0000_00, a};
      hwrite <= w;
      wait_rdy();
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= {24'h0000_00, d};
      wait_rdy();
      q = hrdata[7:0];
   endtask : bus
   // Bounded wait for a level on the first compare pin
   task automatic wait_pin(input logic v, input int lim);
      int n;
      for (n = 0; n < lim && pins[0] !== v; n++) @(posedge clk_sys_i);
      if (pins[0] !== v) begin fails++; end_sim(); end
   endtask : wait_pin
   // Reset values, read-only status, unmapped place
   task automatic t_reset;
      bus(0, timer_ocmp_pkg::OFS_CMP1_HI, 8'h00); `CHK("cmp1_hi", 8'h80, q)
      bus(0, timer_ocmp_pkg::OFS_CMP2_LO, 8'h00); `CHK("cmp2_lo", 8'h00, q)
      bus(1, timer_ocmp_pkg::OFS_STATUS, 8'h07);
      bus(0, timer_ocmp_pkg::OFS_STATUS, 8'h00); `CHK("status", 8'h00, q)
      bus(0, 8'h3C, 8'h00); `CHK("unmapped", 8'h00, q)
      `CHK("pins", 2'b00, pins)
      `CHK("hresp", 1'b0, hresp)
   endtask : t_reset
   // Force copies level to pin without flag or request
   task automatic t_force;
      bus(1, timer_ocmp_pkg::OFS_CTRL_TWO, 8'h01);
      bus(1, timer_ocmp_pkg::OFS_CTRL_ONE, 8'h15);
      repeat (2) @(posedge clk_sys_i);
      `CHK("forced pin", 1'b1, pins[0])
      bus(0, timer_ocmp_pkg::OFS_STATUS, 8'h00); `CHK("flag", 8'h00, q)
      `CHK("irq", 1'b0, irq)
   endtask : t_force
   // High byte alone inhibits; low byte re-enables, match sets all
   task automatic t_match;
      bus(1, timer_ocmp_pkg::OFS_CTRL_ONE, 8'h10);
      bus(1, timer_ocmp_pkg::OFS_CMP1_HI, 8'h00);
      bus(1, timer_ocmp_pkg::OFS_CNT_LO, 8'h00);
      repeat (40) @(posedge clk_sys_i);
      `CHK("inhibited pin", 1'b1, pins[0])
      bus(0, timer_ocmp_pkg::OFS_STATUS, 8'h00); `CHK("flag", 8'h00, q)
      bus(1, timer_ocmp_pkg::OFS_CMP1_LO, 8'h05);
      bus(1, timer_ocmp_pkg::OFS_CNT_LO, 8'h00);
      wait_pin(1'b0, 300);
      @(posedge clk_sys_i);
      `CHK("irq", 1'b1, irq)
      irq_mask <= 1'b1;
      repeat (2) @(posedge clk_sys_i);
      `CHK("masked irq", 1'b0, irq)
      irq_mask <= 1'b0;
      bus(0, timer_ocmp_pkg::OFS_STATUS, 8'h00); `CHK("flag1", 1'b1, q[0])
      bus(0, timer_ocmp_pkg::OFS_CMP1_LO, 8'h00); `CHK("cmp1_lo", 8'h05, q)
      bus(0, timer_ocmp_pkg::OFS_STATUS, 8'h00); `CHK("cleared", 1'b0, q[0])
   endtask : t_match
   // Pin disabled: flag still set, level not applied
   task automatic t_nopin;
      bus(1, timer_ocmp_pkg::OFS_CTRL_TWO, 8'h00);
      bus(1, timer_ocmp_pkg::OFS_CTRL_ONE, 8'h11);
      bus(1, timer_ocmp_pkg::OFS_CNT_LO, 8'h00);
      repeat (40) @(posedge clk_sys_i);
      `CHK("port pin", 1'b0, pins[0])
      `CHK("oe", 2'b00, oe)
      `CHK("irq", 1'b1, irq)
      bus(0, timer_ocmp_pkg::OFS_STATUS, 8'h00); `CHK("flag1", 1'b1, q[0])
      bus(0, timer_ocmp_pkg::OFS_CMP1_LO, 8'h00);
   endtask : t_nopin
   // One pulse: trigger loads counter, capture, level two; match ends it
   task automatic t_pulse;
      bus(1, timer_ocmp_pkg::OFS_CTRL_ONE, 8'h62);
      bus(1, timer_ocmp_pkg::OFS_CTRL_TWO, 8'h05);
      bus(1, timer_ocmp_pkg::OFS_CMP1_LO, 8'h03);
      fire <= 1'b1;
      @(posedge clk_sys_i);
      fire <= 1'b0;
      wait_pin(1'b1, 300);
      wait_pin(1'b0, 300);
      `CHK("width ok", 1'b1, high_cnt >= 16'd14 && high_cnt <= 16'd18)
      bus(0, timer_ocmp_pkg::OFS_STATUS, 8'h00); `CHK("status", 3'b100, q[2:0])
      `CHK("cap irq", 1'b1, irq)
      bus(0, timer_ocmp_pkg::OFS_CAP1_HI, 8'h00); `CHK("cap_hi", 8'hFF, q)
      bus(0, timer_ocmp_pkg::OFS_CAP1_LO, 8'h00); `CHK("cap_lo", 8'hFD, q)
      bus(0, timer_ocmp_pkg::OFS_STATUS, 8'h00); `CHK("capture_flag_one clr", 1'b0, q[2])
   endtask : t_pulse
   // Divide by four: both compares hit at value plus one
   task automatic t_div4;
      bus(1, timer_ocmp_pkg::OFS_CMP2_HI, 8'h00);
      bus(1, timer_ocmp_pkg::OFS_CMP2_LO, 8'h03);
      bus(1, timer_ocmp_pkg::OFS_CTRL_ONE, 8'h03);
      bus(1, timer_ocmp_pkg::OFS_CTRL_TWO, 8'h13);
      bus(1, timer_ocmp_pkg::OFS_CNT_LO, 8'h00);
      wait_pin(1'b1, 300);
      `CHK("both pins", 2'b11, pins)
      bus(0, timer_ocmp_pkg::OFS_CNT_HI, 8'h00);
      `CHK("cnt_hi", 8'h00, q)
      bus(0, timer_ocmp_pkg::OFS_CNT_LO, 8'h00);
      `CHK("cnt_lo", 8'h04, q)
      bus(0, timer_ocmp_pkg::OFS_STATUS, 8'h00);
      `CHK("flags", 3'b011, q[2:0])
      bus(0, timer_ocmp_pkg::OFS_CMP1_LO, 8'h00);
      bus(0, timer_ocmp_pkg::OFS_CMP2_LO, 8'h00);
      `CHK("cmp2_lo", 8'h03, q)
   endtask : t_div4
   // PWM wins over one pulse; compares written now apply at period end
   task automatic t_pwm;
      bus(1, timer_ocmp_pkg::OFS_CTRL_ONE, 8'h06);
      @(posedge clk_sys_i);
      `CHK("forced low", 1'b0, pins[0])
      bus(1, timer_ocmp_pkg::OFS_CTRL_TWO, 8'h0D);
      bus(1, timer_ocmp_pkg::OFS_CMP2_HI, 8'h00);
      bus(1, timer_ocmp_pkg::OFS_CMP2_LO, 8'h08);
      wait_pin(1'b1, 70000);
      wait_pin(1'b0, 300);
      bus(0, timer_ocmp_pkg::OFS_STATUS, 8'h00);
      `CHK("pwm flags", 3'b100, q[2:0])
      wait_pin(1'b1, 300);
      `CHK("pwm oe", 2'b01, oe)
   endtask : t_pwm
   // Clock generator
   initial begin
      clk_sys_i = 1'b0;
      forever #50 clk_sys_i = ~clk_sys_i;
   end
   // Main sequence
   initial begin
      rst_b_i = 1'b0; hsel = 1'b0; haddr = 32'h0000_0000; htrans = 2'b00;
      hwrite = 1'b0; hsize = 3'b010; hwdata = 32'h0000_0000;
      irq_mask = 1'b0; fire = 1'b0; fails = 0; n_tests = 0;
      repeat (10) @(posedge clk_sys_i);
      rst_b_i <= 1'b1;
      @(posedge clk_sys_i);
      t_reset();
      t_force();
      t_match();
      t_nopin();
      t_pulse();
      t_div4();
      t_pwm();
      end_sim();
   end
endmodule : timer_output_compare_pulse_test
